// File: rtl/sfp_port.sv
// Serial audio frame port: bit clock, frame sync, framed and pulse-density data, FIFOs.
//
// Contract
// - Samples shift most significant bit first on both data lines.
// - Frame sync delimits frames; frame length, pulse width and polarity are programmable.
// - One or two channels per direction, 8 to 32 bits, any start, no overlap.
// - Transmit and receive channel formats are configured separately.
// - Bit clock is unrelated to the bus clock; crossing between them is safe.
// - Bit clock inversion swaps the launch and capture edges.
// - Bit clock and frame sync directions are selected independently.
// - Input may take up to two pulse-density microphones while output keeps framing.
// - One FIFO per direction; two channels interleave word by word.
// - FIFOs are serviced by polling, interrupt requests or DMA requests.
// - Outputs change on the rising bit clock edge, inputs sampled on falling; the second pulse-density microphone is sampled on the rising edge.
// - Frame sync is launched like an output and captured like an input.
// - Clock direction select 0 drives the bit clock out from the master clock.
// - Frame sync master generates the sync on the positive edge, usable as I2S select.
// - Frame sync slave samples on falling edge; frame starts on low-to-high sample.
// - In frame sync slave, channel slots follow the detected frame start.
// - Slave with frame length 0 restarts the counter at every frame start.
// - Slave with nonzero frame length runs freely and is only resynchronised.
// - Receive overflow drops samples, transmit underflow sends zeros, error flags set.
// - Separate run controls per direction; interface active when either is set.
// - Narrow channels sit in the low bits of their FIFO word.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
module sfp_port
  import sfp_pkg::*;
#(
  parameter int FIFO_AW   = 6,
  parameter int BCLK_HALF = `SFP_BCLK_HALF
) (
  input  logic         ref_clk,
  input  logic         rst_n,
  input  sfp_bus_req_t bus_req,
  output logic [31:0]  bus_rdata,
  input  logic         bclk_in,
  output logic         bclk_out,
  output logic         bclk_oe,
  input  logic         frame_sync_line_in,
  output logic         frame_sync_line_out,
  output logic         frame_sync_line_oe,
  input  logic         din,
  output logic         dout,
  output logic         tx_srv,
  output logic         rx_srv,
  output logic         tx_dreq,
  output logic         rx_dreq
);
  localparam int AW = FIFO_AW;

  // --------------------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------------------
  if (AW < 2 || AW > 7) begin : g_bad_aw
    $error("FIFO_AW must lie between 2 and 7");
  end
  if (BCLK_HALF < 1 || BCLK_HALF > 65535) begin : g_bad_div
    $error("BCLK_HALF must lie between 1 and 65535");
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    sfp_ctrl_t   ctrl;
    sfp_frame_t  frame;
    sfp_chcfg_t  txc1;
    sfp_chcfg_t  txc2;
    sfp_chcfg_t  rxc1;
    sfp_chcfg_t  rxc2;
    sfp_thr_t    thr;
    logic        tx_err;
    logic        rx_err;
    logic [AW:0] tx_wp;
    logic [AW:0] tx_rp;
    logic [AW:0] rx_wp;
    logic [AW:0] rx_rp;
    logic [15:0] div;
    logic        bclk;
    logic        bc_q;
    logic        bc_qq;
    logic        din_q;
    logic        fs_q;
    logic        fs_prev;
    logic        started;
    logic [9:0]  cur;
    logic [31:0] tx_sh;
    logic [5:0]  tx_left;
    logic [31:0] rx_sh;
    logic [5:0]  rx_left;
    logic [31:0] pd_sh;
    logic [5:0]  pd_left;
    logic        bclk_out;
    logic        bclk_oe;
    logic        fs_out;
    logic        fs_oe;
    logic        dout;
    logic [31:0] rdata;
    logic        tx_srv;
    logic        rx_srv;
    logic        tx_dreq;
    logic        rx_dreq;
  } sfp_st_t;

  localparam sfp_st_t ST_RST = '{
    ctrl: sfp_ctrl_t'(`SFP_CTRL_RST), frame: sfp_frame_t'(`SFP_FRAME_RST),
    txc1: sfp_chcfg_t'(`SFP_CH_RST), txc2: sfp_chcfg_t'(`SFP_CH_RST),
    rxc1: sfp_chcfg_t'(`SFP_CH_RST), rxc2: sfp_chcfg_t'(`SFP_CH_RST),
    thr: sfp_thr_t'(`SFP_THR_RST), default: '0};

  sfp_st_t     r_reg;
  sfp_st_t     r_next;
  logic [31:0] tx_q;
  logic [31:0] rx_q;
  logic        tx_we;
  logic        rx_we;
  logic [31:0] rx_wd;
  logic        rise;
  logic        fall;
  logic        active;
  logic        detect;
  logic        rx_push;
  logic [9:0]  pos;
  logic [9:0]  nxt;
  logic [5:0]  w;
  logic [31:0] word;
  logic [AW:0] tx_lvl;
  logic [AW:0] rx_lvl;
  logic        tx_full;
  logic        rx_full;
  logic        tx_start;
  logic        tx_first;
  logic        rx_start;
  logic        rx_first;
  sfp_ctrl_t   wc;
  sfp_stat_t   stat;

  // Out-of-range widths are clamped so a shift never runs past 32 bits.
  function automatic logic [5:0] eff_w(input logic [5:0] wid);
    if (wid < `SFP_CH_W_MIN) begin
      eff_w = `SFP_CH_W_MIN;
    end else if (wid > `SFP_CH_W_MAX) begin
      eff_w = `SFP_CH_W_MAX;
    end else begin
      eff_w = wid;
    end
  endfunction

  // --------------------------------------------------------------------------
  // FIFO stores
  // --------------------------------------------------------------------------
  sfp_fifo_mem #(.W(32), .AW(AW)) u_tx_mem (
    .ref_clk (ref_clk),
    .we      (tx_we),
    .waddr   (r_reg.tx_wp[AW-1:0]),
    .wdata   (bus_req.wdata),
    .raddr   (r_next.tx_rp[AW-1:0]),
    .rdata   (tx_q)
  );

  sfp_fifo_mem #(.W(32), .AW(AW)) u_rx_mem (
    .ref_clk (ref_clk),
    .we      (rx_we),
    .waddr   (r_reg.rx_wp[AW-1:0]),
    .wdata   (rx_wd),
    .raddr   (r_next.rx_rp[AW-1:0]),
    .rdata   (rx_q)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    r_next   = r_reg;
    tx_we    = 1'b0;
    rx_we    = 1'b0;
    rx_wd    = '0;
    rise     = 1'b0;
    fall     = 1'b0;
    detect   = 1'b0;
    rx_push  = 1'b0;
    pos      = r_reg.cur;
    nxt      = '0;
    w        = '0;
    word     = '0;
    tx_start = 1'b0;
    tx_first = 1'b0;
    rx_start = 1'b0;
    rx_first = 1'b0;
    wc       = sfp_ctrl_t'(bus_req.wdata[9:0]);
    active   = r_reg.ctrl.transmit_run | r_reg.ctrl.receive_run;
    tx_lvl   = r_reg.tx_wp - r_reg.tx_rp;
    rx_lvl   = r_reg.rx_wp - r_reg.rx_rp;
    tx_full  = tx_lvl[AW];
    rx_full  = rx_lvl[AW];
    stat     = '{rx_level: 8'(rx_lvl), tx_level: 8'(tx_lvl),
                 rx_req: r_reg.rx_srv, tx_req: r_reg.tx_srv,
                 rx_empty: (rx_lvl == '0), rx_full: rx_full,
                 tx_empty: (tx_lvl == '0), tx_full: tx_full,
                 receive_error_flag: r_reg.rx_err, transmit_error_flag: r_reg.tx_err};

    // ------------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------------
    r_next.rdata = '0;
    if (bus_req.wr) begin
      unique case (bus_req.addr)
        `SFP_OFF_CTRL: begin
          r_next.ctrl        = wc;
          r_next.ctrl.tx_clr = 1'b0;
          r_next.ctrl.rx_clr = 1'b0;
        end
        `SFP_OFF_STAT: begin
          r_next.tx_err = r_reg.tx_err & ~bus_req.wdata[0];
          r_next.rx_err = r_reg.rx_err & ~bus_req.wdata[1];
        end
        `SFP_OFF_FRAME: r_next.frame = sfp_frame_t'(bus_req.wdata[19:0]);
        `SFP_OFF_TXC1:  r_next.txc1  = sfp_chcfg_t'(bus_req.wdata[16:0]);
        `SFP_OFF_TXC2:  r_next.txc2  = sfp_chcfg_t'(bus_req.wdata[16:0]);
        `SFP_OFF_RXC1:  r_next.rxc1  = sfp_chcfg_t'(bus_req.wdata[16:0]);
        `SFP_OFF_RXC2:  r_next.rxc2  = sfp_chcfg_t'(bus_req.wdata[16:0]);
        `SFP_OFF_THR:   r_next.thr   = sfp_thr_t'(bus_req.wdata[15:0]);
        `SFP_OFF_FIFO: begin
          if (!tx_full) begin
            tx_we        = 1'b1;
            r_next.tx_wp = r_reg.tx_wp + 1'b1;
          end
        end
        default: ;
      endcase
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        `SFP_OFF_CTRL:  r_next.rdata = 32'(r_reg.ctrl);
        `SFP_OFF_STAT:  r_next.rdata = 32'(stat);
        `SFP_OFF_FRAME: r_next.rdata = 32'(r_reg.frame);
        `SFP_OFF_TXC1:  r_next.rdata = 32'(r_reg.txc1);
        `SFP_OFF_TXC2:  r_next.rdata = 32'(r_reg.txc2);
        `SFP_OFF_RXC1:  r_next.rdata = 32'(r_reg.rxc1);
        `SFP_OFF_RXC2:  r_next.rdata = 32'(r_reg.rxc2);
        `SFP_OFF_THR:   r_next.rdata = 32'(r_reg.thr);
        `SFP_OFF_FIFO: begin
          if (rx_lvl != '0) begin
            r_next.rdata = rx_q;
            r_next.rx_rp = r_reg.rx_rp + 1'b1;
          end
        end
        default: ;
      endcase
    end

    // ------------------------------------------------------------------------
    // Bit clock: divided master clock or sampled partner clock
    // ------------------------------------------------------------------------
    r_next.bc_q  = bclk_in ^ r_reg.ctrl.clk_inv;
    r_next.bc_qq = r_reg.bc_q;
    r_next.din_q = din;
    r_next.fs_q  = frame_sync_line_in ^ r_reg.ctrl.fs_inv;
    if (!active) begin
      r_next.div  = '0;
      r_next.bclk = 1'b0;
    end else if (!r_reg.ctrl.clock_direction_select) begin
      if (r_reg.div == 16'(BCLK_HALF - 1)) begin
        r_next.div  = '0;
        r_next.bclk = ~r_reg.bclk;
        rise        = ~r_reg.bclk;
        fall        = r_reg.bclk;
      end else begin
        r_next.div = r_reg.div + 16'h0001;
      end
    end else begin
      rise = r_reg.bc_q & ~r_reg.bc_qq;
      fall = ~r_reg.bc_q & r_reg.bc_qq;
    end
    r_next.bclk_out = r_next.bclk ^ r_reg.ctrl.clk_inv;
    r_next.bclk_oe  = active & ~r_reg.ctrl.clock_direction_select;

    // ------------------------------------------------------------------------
    // Launch edge: frame counter, frame sync and transmit data
    // ------------------------------------------------------------------------
    if (r_reg.frame.frame_len == '0) begin
      nxt = r_reg.ctrl.frame_sync_direction_select ? r_reg.cur + 10'h001 : '0;
    end else begin
      nxt = (r_reg.cur >= r_reg.frame.frame_len) ? '0 : r_reg.cur + 10'h001;
    end
    if (rise) begin
      pos            = r_reg.started ? nxt : '0;
      r_next.cur     = pos;
      r_next.started = 1'b1;
      if (!r_reg.ctrl.frame_sync_direction_select) begin
        r_next.fs_out = (pos < r_reg.frame.fs_len) ^ r_reg.ctrl.fs_inv;
      end
      tx_first = r_reg.txc1.en && (pos == r_reg.txc1.pos);
      tx_start = tx_first || (r_reg.txc2.en && (pos == r_reg.txc2.pos));
      if (tx_start && r_reg.ctrl.transmit_run) begin
        w = eff_w(tx_first ? r_reg.txc1.wid : r_reg.txc2.wid);
        if (tx_lvl == '0) begin
          r_next.tx_err = 1'b1;
        end else begin
          word         = tx_q;
          r_next.tx_rp = r_reg.tx_rp + 1'b1;
        end
        r_next.tx_sh   = word;
        r_next.dout    = word[5'(w - 6'h01)];
        r_next.tx_left = w - 6'h01;
      end else if (r_reg.tx_left != '0) begin
        r_next.dout    = r_reg.tx_sh[5'(r_reg.tx_left - 6'h01)];
        r_next.tx_left = r_reg.tx_left - 6'h01;
      end else begin
        r_next.dout = 1'b0;
      end
      // The second microphone is captured on the launch edge.
      if (r_reg.ctrl.pulse_density_input_mode && r_reg.ctrl.receive_run && r_reg.rxc2.en) begin
        if (r_reg.pd_left == '0) begin
          r_next.pd_sh   = {31'h0000_0000, r_reg.din_q};
          r_next.pd_left = eff_w(r_reg.rxc2.wid) - 6'h01;
        end else begin
          r_next.pd_sh   = {r_reg.pd_sh[30:0], r_reg.din_q};
          r_next.pd_left = r_reg.pd_left - 6'h01;
          if (r_reg.pd_left == 6'h01) begin
            rx_push = 1'b1;
            rx_wd   = r_next.pd_sh;
          end
        end
      end
    end

    // ------------------------------------------------------------------------
    // Capture edge: frame sync detection and receive data
    // ------------------------------------------------------------------------
    if (fall) begin
      r_next.fs_prev = r_reg.fs_q;
      detect = r_reg.ctrl.frame_sync_direction_select & r_reg.fs_q & ~r_reg.fs_prev;
      if (detect) begin
        pos            = '0;
        r_next.cur     = '0;
        r_next.started = 1'b1;
      end
      rx_first = r_reg.rxc1.en && (pos == r_reg.rxc1.pos);
      rx_start = rx_first || (r_reg.rxc2.en && (pos == r_reg.rxc2.pos));
      if (r_reg.ctrl.pulse_density_input_mode) begin
        rx_start = (r_reg.rx_left == '0);
        rx_first = 1'b1;
      end
      if (r_reg.ctrl.receive_run) begin
        if (rx_start) begin
          r_next.rx_sh   = {31'h0000_0000, r_reg.din_q};
          r_next.rx_left = eff_w(rx_first ? r_reg.rxc1.wid : r_reg.rxc2.wid) - 6'h01;
        end else if (r_reg.rx_left != '0) begin
          r_next.rx_sh   = {r_reg.rx_sh[30:0], r_reg.din_q};
          r_next.rx_left = r_reg.rx_left - 6'h01;
          if (r_reg.rx_left == 6'h01) begin
            rx_push = 1'b1;
            rx_wd   = r_next.rx_sh;
          end
        end
      end
    end

    if (rx_push) begin
      if (rx_full) begin
        r_next.rx_err = 1'b1;
      end else begin
        rx_we        = 1'b1;
        r_next.rx_wp = r_reg.rx_wp + 1'b1;
      end
    end

    // ------------------------------------------------------------------------
    // Idle, clears and service requests
    // ------------------------------------------------------------------------
    if (!active) begin
      r_next.cur     = '0;
      r_next.started = 1'b0;
      r_next.tx_left = '0;
      r_next.rx_left = '0;
      r_next.pd_left = '0;
      r_next.fs_prev = 1'b0;
      r_next.dout    = 1'b0;
      r_next.fs_out  = r_reg.ctrl.fs_inv;
    end
    r_next.fs_oe = active & ~r_reg.ctrl.frame_sync_direction_select;
    if (bus_req.wr && bus_req.addr == `SFP_OFF_CTRL) begin
      if (wc.tx_clr) begin
        r_next.tx_rp = r_next.tx_wp;
      end
      if (wc.rx_clr) begin
        r_next.rx_rp = r_next.rx_wp;
      end
    end
    r_next.tx_srv  = 8'(tx_lvl) < r_reg.thr.tx_thr;
    r_next.rx_srv  = (rx_lvl != '0) && (8'(rx_lvl) >= r_reg.thr.rx_thr);
    r_next.tx_dreq = r_next.tx_srv & r_reg.ctrl.dma_en;
    r_next.rx_dreq = r_next.rx_srv & r_reg.ctrl.dma_en;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      r_reg <= ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign bus_rdata           = r_reg.rdata;
  assign bclk_out            = r_reg.bclk_out;
  assign bclk_oe             = r_reg.bclk_oe;
  assign frame_sync_line_out = r_reg.fs_out;
  assign frame_sync_line_oe  = r_reg.fs_oe;
  assign dout                = r_reg.dout;
  assign tx_srv              = r_reg.tx_srv;
  assign rx_srv              = r_reg.rx_srv;
  assign tx_dreq             = r_reg.tx_dreq;
  assign rx_dreq             = r_reg.rx_dreq;
endmodule // sfp_port

// File: rtl/sfp_cfg.svh
// Register offsets, reset values and field limits of the serial audio frame port.
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

// ----------------------------------------------------------------------------
// Register bus
// ----------------------------------------------------------------------------
`define SFP_ADDR_W      6
`define SFP_OFF_CTRL    6'h00
`define SFP_OFF_STAT    6'h04
`define SFP_OFF_FRAME   6'h08
`define SFP_OFF_TXC1    6'h0C
`define SFP_OFF_TXC2    6'h10
`define SFP_OFF_RXC1    6'h14
`define SFP_OFF_RXC2    6'h18
`define SFP_OFF_FIFO    6'h1C
`define SFP_OFF_THR     6'h20

// ----------------------------------------------------------------------------
// Reset values and limits
// ----------------------------------------------------------------------------
`define SFP_CTRL_RST    10'h000
`define SFP_FRAME_RST   20'h00000
`define SFP_CH_RST      17'h00000
`define SFP_THR_RST     16'h0000
`define SFP_CH_W_MIN    6'h08
`define SFP_CH_W_MAX    6'h20
`define SFP_BCLK_HALF   4

`endif

// File: rtl/sfp_pkg.sv
// Types shared by the serial audio frame port.
package sfp_pkg;
  `include "sfp_cfg.svh"

  typedef struct packed {
    logic [`SFP_ADDR_W-1:0] addr;
    logic [31:0]            wdata;
    logic                   wr;
    logic                   rd;
  } sfp_bus_req_t;

  // Control word, bit 0 is transmit_run.
  typedef struct packed {
    logic dma_en;
    logic rx_clr;
    logic tx_clr;
    logic pulse_density_input_mode;
    logic fs_inv;
    logic clk_inv;
    logic frame_sync_direction_select;
    logic clock_direction_select;
    logic receive_run;
    logic transmit_run;
  } sfp_ctrl_t;

  typedef struct packed {
    logic [9:0] fs_len;
    logic [9:0] frame_len;
  } sfp_frame_t;

  typedef struct packed {
    logic       en;
    logic [5:0] wid;
    logic [9:0] pos;
  } sfp_chcfg_t;

  typedef struct packed {
    logic [7:0] rx_thr;
    logic [7:0] tx_thr;
  } sfp_thr_t;

  typedef struct packed {
    logic [7:0] rx_level;
    logic [7:0] tx_level;
    logic       rx_req;
    logic       tx_req;
    logic       rx_empty;
    logic       rx_full;
    logic       tx_empty;
    logic       tx_full;
    logic       receive_error_flag;
    logic       transmit_error_flag;
  } sfp_stat_t;
endpackage

// File: rtl/sfp_fifo_mem.sv
// Word store of one FIFO with a registered read port.
`timescale 1ns/1ns
module sfp_fifo_mem #(
  parameter int W  = 32,
  parameter int AW = 6
) (
  input  logic          ref_clk,
  input  logic          we,
  input  logic [AW-1:0] waddr,
  input  logic [W-1:0]  wdata,
  input  logic [AW-1:0] raddr,
  output logic [W-1:0]  rdata
);
  logic [W-1:0] mem [2**AW];

  // A write to the address being read is passed through so the head is never stale.
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // sfp_fifo_mem

// File: tb/sfp_port_assertions.sv
// Pin-level checker of the serial audio frame port.
`timescale 1ns/1ns
module sfp_port_chk
  import sfp_pkg::*;
#(
  parameter int BCLK_HALF = 4
) (
  input wire logic         ref_clk,
  input wire logic         rst_n,
  input wire sfp_bus_req_t bus_req,
  input wire logic [31:0]  bus_rdata,
  input wire logic         bclk_out,
  input wire logic         bclk_oe,
  input wire logic         frame_sync_line_out,
  input wire logic         frame_sync_line_oe,
  input wire logic         dout,
  input wire logic         tx_srv,
  input wire logic         rx_srv,
  input wire logic         tx_dreq,
  input wire logic         rx_dreq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic       bclk_q;
  logic [7:0] gap_q;
  // Counts cycles since the driven bit clock last changed.
  always_ff @(posedge ref_clk) begin
    bclk_q <= bclk_out;
    if (!rst_n || !bclk_oe || bclk_out != bclk_q) begin
      gap_q <= 8'h00;
    end else begin
      gap_q <= gap_q + 8'h01;
    end
  end
  chk_rdata_quiet: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_reset_quiet: assert property ($rose(rst_n) |->
    !bclk_oe && !frame_sync_line_oe && !dout && !tx_srv)
    else $error("outputs active after reset");
  chk_half_period: assert property (bclk_oe && $past(bclk_oe, 4) && $changed(bclk_out) |->
    gap_q == BCLK_HALF - 1)
    else $error("bit clock half period wrong");
  chk_dout_launch: assert property (bclk_oe && $past(bclk_oe) && $changed(dout) |->
    $changed(bclk_out))
    else $error("data changed off the launch edge");
  chk_fs_launch: assert property (bclk_oe && frame_sync_line_oe && $past(frame_sync_line_oe)
    && $changed(frame_sync_line_out) |-> $changed(bclk_out))
    else $error("frame sync changed off the launch edge");
  chk_dout_stop: assert property ($fell(bclk_oe) |-> !dout)
    else $error("data not idle after stop");
  chk_tx_dma: assert property (tx_dreq |-> tx_srv)
    else $error("transmit dma request without service need");
  chk_rx_dma: assert property (rx_dreq |-> rx_srv)
    else $error("receive dma request without service need");
  cov_fs_pulse: cover property ($rose(frame_sync_line_out) && frame_sync_line_oe);
  cov_rx_srv: cover property ($rose(rx_srv));
  cov_tx_dreq: cover property (tx_dreq);
endmodule  // sfp_port_chk

bind sfp_port sfp_port_chk #(.BCLK_HALF(BCLK_HALF)) chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
  .bclk_out(bclk_out), .bclk_oe(bclk_oe), .frame_sync_line_out(frame_sync_line_out),
  .frame_sync_line_oe(frame_sync_line_oe), .dout(dout), .tx_srv(tx_srv), .rx_srv(rx_srv),
  .tx_dreq(tx_dreq), .rx_dreq(rx_dreq));

// File: tb/sfp_codec_model.sv
// Codec model that masters bit clock and frame sync and loops data back.
`timescale 1ns/1ns
module sfp_codec_model (
  input  wire logic   ref_clk,
  input  wire logic   run,
  input  wire logic   dout,
  output logic        bclk = 1'b0,
  output logic        fs = 1'b0,
  output logic        din,
  output logic [31:0] cap = 32'h0
);
  logic [2:0] div  = 3'h0;
  logic [4:0] pos  = 5'h00;
  logic       done = 1'b0;
  assign din = dout;
  // The clock stands low between runs; the first frame is captured bit by bit.
  always @(posedge ref_clk) begin
    if (!run) begin
      bclk <= 1'b0;
      fs <= 1'b0;
      div <= 3'h0;
      pos <= 5'h00;
      done <= 1'b0;
    end else if (div != 3'h4) begin
      div <= div + 3'h1;
    end else begin
      div <= 3'h0;
      bclk <= !bclk;
      if (!bclk) begin
        fs <= (pos == 5'h00);
      end else begin
        if (!done) cap[5'd31 - pos] <= dout;
        done <= done | (pos == 5'h1F);
        pos <= pos + 5'h01;
      end
    end
  end
endmodule  // sfp_codec_model

// File: tb/sfp_port_bench.sv
// Register-level bench of the serial audio frame port.
`timescale 1ns/1ns
`include "sfp_cfg.svh"
module sfp_port_bench
  import sfp_pkg::*;
;
  logic         ref_clk = 1'b0;
  logic         rst_n   = 1'b0;
  sfp_bus_req_t bus_req = '0;
  logic         p_run   = 1'b0;
  logic         mon_on  = 1'b0;
  logic         prev_b  = 1'b0;
  logic [31:0]  bus_rdata, cap, mon_d, mon_f;
  logic         bclk_out, bclk_oe, fs_out, fs_oe, dout, tx_srv, rx_srv, tx_dreq, rx_dreq;
  logic         p_bclk, p_fs, p_din;
  wire          bclk_pin = bclk_oe ? bclk_out : p_bclk;
  wire          fs_pin   = fs_oe ? fs_out : p_fs;
  int           miscompares = 0, checks_done = 0, cyc = 0, mon_n = 0;

  always #10 ref_clk = ~ref_clk;

  sfp_port #(.FIFO_AW(6), .BCLK_HALF(2)) dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .bclk_in(bclk_pin), .bclk_out(bclk_out), .bclk_oe(bclk_oe),
    .frame_sync_line_in(fs_pin), .frame_sync_line_out(fs_out), .frame_sync_line_oe(fs_oe),
    .din(p_din), .dout(dout), .tx_srv(tx_srv), .rx_srv(rx_srv),
    .tx_dreq(tx_dreq), .rx_dreq(rx_dreq));

  sfp_codec_model codec_u (.ref_clk(ref_clk), .run(p_run), .dout(dout), .bclk(p_bclk),
    .fs(p_fs), .din(p_din), .cap(cap));

  task automatic results();
    $display("Comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string nm);
    @(posedge ref_clk);
    bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    #1 chk(nm, e, bus_rdata & m);
  endtask

  // Records data and frame sync at the first 32 driven bit clock rises.
  always @(posedge ref_clk) begin
    prev_b <= bclk_out;
    cyc <= cyc + 1;
    if (mon_on && bclk_oe && bclk_out && !prev_b && mon_n < 32) begin
      mon_d[31-mon_n] <= dout;
      mon_f[31-mon_n] <= fs_out;
      mon_n <= mon_n + 1;
    end
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(`SFP_OFF_CTRL, 32'h0, 32'hFFFF_FFFF, "ctrl");
    rdc(`SFP_OFF_STAT, 32'h28, 32'hFFFF_FFFF, "stat");
    rdc(`SFP_OFF_FRAME, 32'h0, 32'hFFFF_FFFF, "frame");
    rdc(`SFP_OFF_TXC1, 32'h0, 32'hFFFF_FFFF, "txc1");
    rdc(`SFP_OFF_RXC2, 32'h0, 32'hFFFF_FFFF, "rxc2");
    wr(6'h24, 32'hFFFF_FFFF);
    rdc(6'h24, 32'h0, 32'hFFFF_FFFF, "unmapped");
    wr(`SFP_OFF_CTRL, 32'h0000_01FC);
    rdc(`SFP_OFF_CTRL, 32'h0000_007C, 32'hFFFF_FFFF, "ctrl_rw");
    chk("bclk_idle_inv", 32'h1, bclk_out);
    chk("fs_idle_inv", 32'h1, fs_out);
    wr(`SFP_OFF_CTRL, 32'h0);
    $display("Test registers done");
    wr(`SFP_OFF_FRAME, 32'h0000_041F);
    wr(`SFP_OFF_TXC1, 32'h0001_2001);
    wr(`SFP_OFF_TXC2, 32'h0001_400C);
    wr(`SFP_OFF_RXC1, 32'h0001_2001);
    wr(`SFP_OFF_RXC2, 32'h0001_400C);
    wr(`SFP_OFF_THR, 32'h0000_0104);
    wr(`SFP_OFF_CTRL, 32'h0000_0200);
    repeat (3) @(posedge ref_clk);
    chk("tx_dreq", 32'h1, tx_dreq);
    wr(`SFP_OFF_FIFO, 32'h0000_00A5);
    wr(`SFP_OFF_FIFO, 32'h0000_1234);
    mon_on <= 1'b1;
    wr(`SFP_OFF_CTRL, 32'h0000_0203);
    repeat (4500) @(posedge ref_clk);
    chk("rx_dreq", 32'h1, rx_dreq);
    wr(`SFP_OFF_CTRL, 32'h0000_0200);
    chk("dout_frame", {1'b0, 8'hA5, 3'h0, 16'h1234, 4'h0}, mon_d);
    chk("fs_frame", 32'h8000_0000, mon_f);
    rdc(`SFP_OFF_STAT, 32'h0040_001B, 32'h00FF_FF3F, "stat_err");
    rdc(`SFP_OFF_FIFO, 32'h0000_00A5, 32'hFFFF_FFFF, "rx_ch1");
    rdc(`SFP_OFF_FIFO, 32'h0000_1234, 32'hFFFF_FFFF, "rx_ch2");
    wr(`SFP_OFF_STAT, 32'h3);
    rdc(`SFP_OFF_STAT, 32'h0, 32'h3, "err_clear");
    $display("Test master done");
    for (int m = 0; m < 2; m++) begin
      wr(`SFP_OFF_CTRL, 32'h0000_0080);
      wr(`SFP_OFF_FRAME, (m == 1) ? 32'h0000_0400 : 32'h0000_041F);
      wr(`SFP_OFF_FIFO, 32'h0000_005A);
      wr(`SFP_OFF_CTRL, 32'h0000_000D);
      p_run <= 1'b1;
      repeat (700) @(posedge ref_clk);
      chk("bclk_oe", 32'h0, bclk_oe);
      chk("fs_oe", 32'h0, fs_oe);
      chk("slave_ch1", 32'h5A, cap[30:23]);
      p_run <= 1'b0;
      wr(`SFP_OFF_CTRL, 32'h0);
    end
    $display("Test slave done");
    results();
  end
endmodule  // sfp_port_bench
